/* File: shared/ssby_pkg.sv */
// Shared constants and types for the software standby entry controller.
package ssby_pkg;
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 8;
    localparam int          CNT_W        = 8;
    localparam int          PRESC_W      = 12;
    localparam int          CKS_W        = 3;

    // Register byte addresses.
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_WDCS    = 4'h4;
    localparam logic [3:0]  ADDR_WDCNT   = 4'h8;
    localparam logic [3:0]  ADDR_STAT    = 4'hc;

    // Standby control register fields.
    localparam int          CTRL_STANDBY_SELECT    = 7;
    localparam int          CTRL_SELA    = 6;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  CTRL_MASK    = 8'hc0;

    // Watchdog control and status fields.
    localparam int          WDCS_OVF     = 7;
    localparam int          WDCS_TME     = 6;
    localparam int          WDCS_CKS_LO  = 0;
    localparam logic [7:0]  WDCS_RST     = 8'h00;
    localparam logic [7:0]  WDCS_MASK    = 8'h47;

    localparam logic [7:0]  CNT_RST      = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hff;
    localparam logic [11:0] PRESC_RST    = 12'h000;
    localparam logic [7:0]  RD_ZERO      = 8'h00;

    // One-hot controller states.
    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_STANDBY_SELECT   = 3'b010,
        ST_SETTLE = 3'b100
    } ssby_state_t;

    // Halt controls handed to the rest of the chip.
    typedef struct packed {
        logic core;
        logic clocks;
        logic periph;
        logic ext_clk;
    } ssby_halt_t;

    localparam ssby_halt_t HALT_NONE = '{core: 1'b0, clocks: 1'b0, periph: 1'b0, ext_clk: 1'b0};
    localparam ssby_halt_t HALT_ALL  = '{core: 1'b1, clocks: 1'b1, periph: 1'b1, ext_clk: 1'b1};
endpackage

/* File: rtl/ssby_wdog.sv */
// Watchdog counter with a selectable prescaler, used to time oscillator settling.
`timescale 1ns/100ps
module ssby_wdog (
    input  wire logic                         i_mclk,      // System clock.
    input  wire logic                         i_sys_rst,   // Synchronous reset, active high.
    input  wire logic                         i_run,       // Counter advances while high.
    input  wire logic [ssby_pkg::CKS_W-1:0]   i_cks,       // Prescaler tap select.
    input  wire logic                         i_cnt_wr,    // Load strobe for the counter.
    input  wire logic [ssby_pkg::CNT_W-1:0]   i_cnt_wdata, // Value to load.
    output logic      [ssby_pkg::CNT_W-1:0]   o_cnt,       // Current count.
    output logic                              o_ovf        // One-cycle pulse on wrap.
);
    logic [ssby_pkg::PRESC_W-1:0] presc_q;
    logic [ssby_pkg::CNT_W-1:0]   cnt_q;
    logic                         ovf_q;
    logic                         tick;

    // Divide ratios 1, 4, 16, 32, 64, 256, 1024 and 4096 system clocks.
    function automatic logic [ssby_pkg::PRESC_W-1:0] tap_mask(
        input logic [ssby_pkg::CKS_W-1:0] watchdog_clock_select);
        unique case (watchdog_clock_select)
            3'h0:    tap_mask = 12'h000;
            3'h1:    tap_mask = 12'h003;
            3'h2:    tap_mask = 12'h00f;
            3'h3:    tap_mask = 12'h01f;
            3'h4:    tap_mask = 12'h03f;
            3'h5:    tap_mask = 12'h0ff;
            3'h6:    tap_mask = 12'h3ff;
            default: tap_mask = 12'hfff;
        endcase
    endfunction

    assign tick = i_run && ((presc_q & tap_mask(i_cks)) == tap_mask(i_cks));

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !i_run) begin
            presc_q <= ssby_pkg::PRESC_RST;
        end else begin
            presc_q <= presc_q + 12'h001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt_q <= ssby_pkg::CNT_RST;
            ovf_q <= 1'b0;
        end else if (i_cnt_wr) begin
            cnt_q <= i_cnt_wdata;
            ovf_q <= 1'b0;
        end else begin
            if (tick) begin
                cnt_q <= cnt_q + 8'h01;
            end
            ovf_q <= tick && (cnt_q == ssby_pkg::CNT_MAX);
        end
    end

    assign o_cnt = cnt_q;
    assign o_ovf = ovf_q;
endmodule

/* File: rtl/ssby_ctrl.sv */
// Software standby entry controller with its registers and settling watchdog.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Summary of operation
// - Sleep with standby select 1 and select_a 0 enters software standby.
// - Standby halts the core, internal clocks and all peripheral modules.
// - Standby stops the external clock output pin.
// - Core and cache register contents stay unchanged on standby entry.
// - Entry pulses an initialise strobe for a subset of peripheral registers.
// - A standby control write takes effect two cycles later.
module ssby_ctrl (
    input  wire logic                          i_mclk,     // System clock, 25 MHz.
    input  wire logic                          i_sys_rst,  // Synchronous reset, active high.
    input  wire logic [ssby_pkg::ADDR_W-1:0]   i_addr,     // Register byte address.
    input  wire logic [ssby_pkg::DATA_W-1:0]   i_wdata,    // Register write data.
    input  wire logic                          i_wr,       // Write strobe.
    input  wire logic                          i_rd,       // Read strobe.
    output logic      [ssby_pkg::DATA_W-1:0]   o_rdata,    // Read data, cycle after i_rd.
    input  wire logic                          i_sleep,    // Core executes sleep, one pulse.
    input  wire logic                          i_wake,     // Wake-up event from standby.
    output ssby_pkg::ssby_halt_t               o_halt,     // Halt controls, registered.
    output logic                               o_periph_init, // Peripheral init pulse.
    output logic                               o_core_retain  // Core state must be kept.
);
    ssby_pkg::ssby_state_t        state_q;
    ssby_pkg::ssby_state_t        state_d;
    logic [ssby_pkg::DATA_W-1:0]  ctrl_q;
    logic [ssby_pkg::DATA_W-1:0]  ctrl_pend_q;
    logic                         pend_v_q;
    logic [ssby_pkg::DATA_W-1:0]  wdcs_q;
    logic [ssby_pkg::DATA_W-1:0]  rdata_q;
    ssby_pkg::ssby_halt_t         halt_q;
    logic                         init_q;
    logic                         retain_q;
    logic [ssby_pkg::CNT_W-1:0]   wd_cnt;
    logic                         wd_ovf;
    logic                         wd_run;
    logic                         wr_ctrl;
    logic                         wr_wdcs;
    logic                         wr_cnt;
    logic                         enter_req;

    function automatic logic low_power(input ssby_pkg::ssby_state_t st);
        low_power = (st != ssby_pkg::ST_RUN);
    endfunction

    assign wr_ctrl = i_wr && (i_addr == ssby_pkg::ADDR_CTRL);
    assign wr_wdcs = i_wr && (i_addr == ssby_pkg::ADDR_WDCS);
    assign wr_cnt  = i_wr && (i_addr == ssby_pkg::ADDR_WDCNT);

    // posted control write
    // The write lands in a holding stage and commits one edge later, so a
    // sleep in the very next cycle may still see the old selection.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_pend_q <= ssby_pkg::CTRL_RST;
            pend_v_q    <= 1'b0;
        end else begin
            pend_v_q <= wr_ctrl;
            if (wr_ctrl) begin
                ctrl_pend_q <= i_wdata & ssby_pkg::CTRL_MASK;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_q <= ssby_pkg::CTRL_RST;
        end else if (pend_v_q) begin
            ctrl_q <= ctrl_pend_q;
        end
    end

    // Overflow flag: writing 0 clears it, but a new overflow wins.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wdcs_q <= ssby_pkg::WDCS_RST;
        end else begin
            if (wr_wdcs) begin
                wdcs_q <= (i_wdata & ssby_pkg::WDCS_MASK)
                        | ((wdcs_q[ssby_pkg::WDCS_OVF] & i_wdata[ssby_pkg::WDCS_OVF])
                           ? 8'h80 : 8'h00);
            end
            if (wd_ovf) begin
                wdcs_q[ssby_pkg::WDCS_OVF] <= 1'b1;
            end
        end
    end

    // Reads of the control register forward a posted value so that a
    // read-back right after a write already shows the new selection.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rdata_q <= ssby_pkg::RD_ZERO;
        end else if (i_rd) begin
            unique case (i_addr)
                ssby_pkg::ADDR_CTRL:  rdata_q <= pend_v_q ? ctrl_pend_q : ctrl_q;
                ssby_pkg::ADDR_WDCS:  rdata_q <= wdcs_q;
                ssby_pkg::ADDR_WDCNT: rdata_q <= wd_cnt;
                ssby_pkg::ADDR_STAT:  rdata_q <= {5'h00, state_q};
                default:              rdata_q <= ssby_pkg::RD_ZERO;
            endcase
        end else begin
            rdata_q <= ssby_pkg::RD_ZERO;
        end
    end

    assign enter_req = i_sleep && ctrl_q[ssby_pkg::CTRL_STANDBY_SELECT]
                       && !ctrl_q[ssby_pkg::CTRL_SELA];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ssby_pkg::ST_RUN: begin
                if (enter_req) begin
                    state_d = ssby_pkg::ST_STANDBY_SELECT;
                end
            end
            ssby_pkg::ST_STANDBY_SELECT: begin
                if (i_wake) begin
                    state_d = ssby_pkg::ST_SETTLE;
                end
            end
            ssby_pkg::ST_SETTLE: begin
                if (wd_ovf) begin
                    state_d = ssby_pkg::ST_RUN;
                end
            end
            default: state_d = ssby_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_q <= ssby_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // halt core, clocks and pin
    // The external clock stops together with the internal ones; the settling
    // phase keeps everything stopped while the oscillator is unproven.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            halt_q <= ssby_pkg::HALT_NONE;
        end else begin
            halt_q <= low_power(state_d) ? ssby_pkg::HALT_ALL : ssby_pkg::HALT_NONE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            init_q <= 1'b0;
        end else begin
            init_q <= (state_q == ssby_pkg::ST_RUN) && enter_req;
        end
    end

    // keep core and cache state
    // Only the system reset may clear core state; standby never does.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            retain_q <= 1'b0;
        end else begin
            retain_q <= low_power(state_d);
        end
    end

    // watchdog restarts on wake
    // In run mode the counter follows its enable bit; in standby it is held,
    // and during settling it runs whatever software left in the enable bit.
    assign wd_run = (state_q == ssby_pkg::ST_SETTLE)
                    || ((state_q == ssby_pkg::ST_RUN) && wdcs_q[ssby_pkg::WDCS_TME]);

    ssby_wdog u_wdog (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_run       (wd_run),
        .i_cks       (wdcs_q[ssby_pkg::WDCS_CKS_LO +: ssby_pkg::CKS_W]),
        .i_cnt_wr    (wr_cnt),
        .i_cnt_wdata (i_wdata),
        .o_cnt       (wd_cnt),
        .o_ovf       (wd_ovf)
    );

    assign o_rdata       = rdata_q;
    assign o_halt        = halt_q;
    assign o_periph_init = init_q;
    assign o_core_retain = retain_q;

    a_entry_on_sleep: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q == ssby_pkg::ST_RUN) && enter_req |=> (state_q == ssby_pkg::ST_STANDBY_SELECT))
        else $error("Sleep with standby selected did not enter standby.");

    a_no_entry_sela: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q == ssby_pkg::ST_RUN) && ctrl_q[ssby_pkg::CTRL_SELA] |=>
        (state_q == ssby_pkg::ST_RUN))
        else $error("Standby entered with select_a set.");

    a_core_halted: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(state_q == ssby_pkg::ST_STANDBY_SELECT) |-> o_halt.core && o_halt.clocks && o_halt.periph)
        else $error("Core, clocks or peripherals running in standby.");

    a_ext_clk_stop: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q != ssby_pkg::ST_RUN) |=> o_halt.ext_clk || (state_q == ssby_pkg::ST_RUN))
        else $error("External clock still driven in standby.");

    a_retain_core: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(o_halt.core) |-> o_core_retain)
        else $error("Core retention not asserted at standby entry.");

    a_init_pulse: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_periph_init |-> $rose(state_q == ssby_pkg::ST_STANDBY_SELECT) ##1 !o_periph_init)
        else $error("Peripheral init pulse not tied to standby entry.");

    a_ctrl_delay: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_ctrl |-> ##2 (ctrl_q == $past(i_wdata & ssby_pkg::CTRL_MASK, 2)) || $past(wr_ctrl))
        else $error("Control write did not commit two edges later.");

    a_settle_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q == ssby_pkg::ST_SETTLE) && !wd_ovf |=> o_halt.clocks)
        else $error("Clocks released before settling overflow.");

    a_settle_done: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q == ssby_pkg::ST_SETTLE) && wd_ovf |=> ##1 !o_halt.clocks)
        else $error("Clocks not released after settling overflow.");

    c_enter: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(state_q == ssby_pkg::ST_STANDBY_SELECT));
    c_wake: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(state_q == ssby_pkg::ST_SETTLE));
    c_resume: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state_q == ssby_pkg::ST_SETTLE) ##1 (state_q == ssby_pkg::ST_RUN));
endmodule

/* File: dv/ssby_core_model.sv */
// Processor core model: register accesses, the standby preparation and the sleep and wake events.
`timescale 1ns/100ps
module ssby_core_model (
    input  wire logic       i_mclk,  // System clock.
    input  wire logic [7:0] i_rdata, // Read data from the controller.
    output logic      [3:0] o_addr,  // Register byte address.
    output logic      [7:0] o_wdata, // Register write data.
    output logic            o_wr,    // Write strobe.
    output logic            o_rd,    // Read strobe.
    output logic            o_sleep, // Sleep instruction pulse.
    output logic            o_wake   // Wake-up event.
);
    initial begin
        o_addr  = 4'h0;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_sleep = 1'b0;
        o_wake  = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_mclk);
        o_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_mclk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    // Sleep issued in the very next cycle after a control write, with no read-back.
    task automatic wr_sleep(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        o_sleep <= 1'b1;
        @(posedge i_mclk);
        o_sleep <= 1'b0;
    endtask

    task automatic sleep();
        @(posedge i_mclk);
        o_sleep <= 1'b1;
        @(posedge i_mclk);
        o_sleep <= 1'b0;
    endtask

    task automatic wake();
        @(posedge i_mclk);
        o_wake <= 1'b1;
        @(posedge i_mclk);
        o_wake <= 1'b0;
    endtask

    // The watchdog is stopped, zeroed and given the tap passed in before standby is asked for.
    task automatic prep(input logic [2:0] watchdog_clock_select);
        wr(ssby_pkg::ADDR_WDCS, {5'h00, watchdog_clock_select});
        wr(ssby_pkg::ADDR_WDCNT, 8'h00);
    endtask

    task automatic enter(output logic [7:0] back);
        wr(ssby_pkg::ADDR_CTRL, 8'h80);
        rd(ssby_pkg::ADDR_CTRL, back);
        sleep();
    endtask
endmodule

/* File: dv/ssby_ctrl_tb.sv */
// Self-checking testbench for the software standby entry controller.
`timescale 1ns/100ps
module ssby_ctrl_tb;
    logic                 i_mclk    = 1'b0;
    logic                 i_sys_rst = 1'b1;
    logic [3:0]           addr;
    logic [7:0]           wdata;
    logic                 wr;
    logic                 rd;
    logic                 sleep;
    logic                 wake;
    logic [7:0]           rdata;
    ssby_pkg::ssby_halt_t halt;
    logic                 pinit;
    logic                 retain;
    logic [7:0]           d;
    int                   error_cnt = 0;
    int                   n_compared = 0;
    int                   n;

    always #20 i_mclk = ~i_mclk;

    ssby_core_model core_u (
        .i_mclk  (i_mclk),
        .i_rdata (rdata),
        .o_addr  (addr),
        .o_wdata (wdata),
        .o_wr    (wr),
        .o_rd    (rd),
        .o_sleep (sleep),
        .o_wake  (wake)
    );

    ssby_ctrl dut_u (
        .i_mclk        (i_mclk),
        .i_sys_rst     (i_sys_rst),
        .i_addr        (addr),
        .i_wdata       (wdata),
        .i_wr          (wr),
        .i_rd          (rd),
        .o_rdata       (rdata),
        .i_sleep       (sleep),
        .i_wake        (wake),
        .o_halt        (halt),
        .o_periph_init (pinit),
        .o_core_retain (retain)
    );

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        core_u.rd(a, v);
        chk(name, exp, v);
    endtask

    task automatic outs_chk(input logic [3:0] h, input logic pi, input logic rt);
        chk("halt", {4'h0, h}, {4'h0, halt});
        chk("periph_init", {7'h00, pi}, {7'h00, pinit});
        chk("core_retain", {7'h00, rt}, {7'h00, retain});
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge i_mclk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        #1;
        outs_chk(4'h0, 1'b0, 1'b0);
        rd_chk("ctrl_rst", ssby_pkg::ADDR_CTRL, 8'h00);
        rd_chk("wdcs_rst", ssby_pkg::ADDR_WDCS, 8'h00);
        rd_chk("cnt_rst", ssby_pkg::ADDR_WDCNT, 8'h00);
        rd_chk("stat_rst", ssby_pkg::ADDR_STAT, 8'h01);
        core_u.wr(4'h2, 8'hff);
        rd_chk("unmapped", 4'h2, 8'h00);
        core_u.wr(ssby_pkg::ADDR_WDCS, 8'hff);
        rd_chk("wdcs_mask", ssby_pkg::ADDR_WDCS, 8'h47);
        core_u.wr(ssby_pkg::ADDR_CTRL, 8'hff);
        rd_chk("ctrl_mask", ssby_pkg::ADDR_CTRL, 8'hc0);
        // Select_a select set, then standby select clear: sleep must be ignored both times.
        core_u.sleep();
        #1;
        outs_chk(4'h0, 1'b0, 1'b0);
        core_u.wr(ssby_pkg::ADDR_CTRL, 8'h00);
        rd_chk("ctrl_clear", ssby_pkg::ADDR_CTRL, 8'h00);
        core_u.sleep();
        #1;
        outs_chk(4'h0, 1'b0, 1'b0);
        // Sleep right behind the write lands before the write has taken effect.
        core_u.wr_sleep(ssby_pkg::ADDR_CTRL, 8'h80);
        #1;
        outs_chk(4'h0, 1'b0, 1'b0);
        rd_chk("stat_run", ssby_pkg::ADDR_STAT, 8'h01);
        core_u.prep(3'h0);
        repeat (4) @(posedge i_mclk);
        rd_chk("cnt_stopped", ssby_pkg::ADDR_WDCNT, 8'h00);
        core_u.enter(d);
        #1;
        chk("ctrl_back", 8'h80, d);
        outs_chk(4'hf, 1'b1, 1'b1);
        @(posedge i_mclk);
        #1;
        outs_chk(4'hf, 1'b0, 1'b1);
        rd_chk("stat_standby_select", ssby_pkg::ADDR_STAT, 8'h02);
        repeat (10) @(posedge i_mclk);
        #1;
        outs_chk(4'hf, 1'b0, 1'b1);
        core_u.wake();
        #1;
        n = 0;
        while (halt !== ssby_pkg::HALT_NONE && n < 400) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        // About 256 counts at one clock per count, plus the pulse and the state change.
        chk("settle_len", 8'h01, {7'h00, (n >= 250 && n <= 262)});
        outs_chk(4'h0, 1'b0, 1'b0);
        rd_chk("stat_back", ssby_pkg::ADDR_STAT, 8'h01);
        // The settling overflow leaves its flag set; writing 1 keeps it, 0 clears it.
        rd_chk("wdcs_ovf", ssby_pkg::ADDR_WDCS, 8'h80);
        core_u.wr(ssby_pkg::ADDR_WDCS, 8'h80);
        rd_chk("wdcs_keep", ssby_pkg::ADDR_WDCS, 8'h80);
        core_u.wr(ssby_pkg::ADDR_WDCS, 8'h00);
        rd_chk("wdcs_clr", ssby_pkg::ADDR_WDCS, 8'h00);
        tally_and_finish();
    end
endmodule
